// ### rtl/nibble_add_defines.vh
// opcode prefixes, field positions and reset values for the nibble add unit
// assumes a 16-bit instruction word, 4-bit data and a 7-bit data address
`ifndef NIBBLE_ADD_DEFINES_VH
`define NIBBLE_ADD_DEFINES_VH
`define OP_CARRY_MEM    9'h020
`define OP_CARRY_WB_MEM 9'h024
`define OP_PLAIN_MEM    9'h030
`define OP_PLAIN_WB_MEM 9'h032
`define OP_KEEP_MEM     9'h050
`define OP_KEEP_WB_MEM  9'h052
`define OP_CARRY_IMM    8'h0C
`define OP_CARRY_WB_IMM 8'h0D
`define OP_PLAIN_IMM    8'h1C
`define OP_PLAIN_WB_IMM 8'h1D
`define OP_KEEP_IMM     8'h2C
`define OP_KEEP_WB_IMM  8'h2D
`define MEM_PREFIX_MSB  15
`define MEM_PREFIX_LSB  7
`define IMM_PREFIX_MSB  15
`define IMM_PREFIX_LSB  8
`define ADDR_MSB        6
`define ADDR_LSB        0
`define IMM_MSB         7
`define IMM_LSB         4
`define WSEL_MSB        3
`define WSEL_LSB        0
`define ACC_RESET       4'h0
`define FLAG_RESET      1'b0
`define WREG_RESET      4'h0
`endif

// ### rtl/nibble_adder.v
// 4-bit binary adder with carry in, carry out and zero detect
// assumes purely combinational use inside the add unit
`timescale 1ns/1ps
module nibble_adder #(
	parameter WIDTH = 4
) (
	input  wire [WIDTH-1:0] a,
	input  wire [WIDTH-1:0] b,
	input  wire             cin,
	output wire [WIDTH-1:0] sum,
	output wire             cout,
	output wire             zero
);
	wire [WIDTH:0] full;
	assign full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
	assign sum  = full[WIDTH-1:0];
	assign cout = full[WIDTH];
	assign zero = (full[WIDTH-1:0] == {WIDTH{1'b0}});
endmodule

// ### rtl/work_reg_file.v
// sixteen-entry working register file, one write port and one read port
// assumes writes come from the add unit only, in the cycle they are decided
`timescale 1ns/1ps
`include "nibble_add_defines.vh"
module work_reg_file #(
	parameter WIDTH = 4,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             mclk,
	input  wire             rst,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_sel,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [AW-1:0]    rd_sel,
	output wire [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] regs [0:DEPTH-1];
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
			localparam [AW-1:0] IDX = i;
			always @(posedge mclk) begin
				if (rst) begin
					regs[i] <= `WREG_RESET;
				end else if (wr_en && (wr_sel == IDX)) begin
					regs[i] <= wr_data;
				end
			end
		end
	endgenerate
	// combinational read so the operand is ready in the same machine cycle
	assign rd_data = regs[rd_sel];
endmodule

// ### rtl/nibble_add_instruction_unit.v
// Summary of operation
// - carry add of memory nibble: acc gets mem+acc+carry, both flags update
// - carry add immediate: acc gets wreg+imm+carry, wreg kept, both flags
// - carry add memory writeback: sum to acc and memory, both flags
// - carry add immediate writeback: sum to acc and wreg, both flags
// - plain add memory: acc gets mem+acc, no carry in, both flags
// - plain add immediate: acc gets wreg+imm, no carry in, wreg kept
// - plain add memory writeback: sum to acc and memory, both flags
// - plain add immediate writeback: sum to acc and wreg, both flags
// - keep-carry add memory: acc gets mem+acc, only zero flag updates
// - memory forms take a 7-bit address from instruction bits six to zero
// - immediate forms: 8-bit prefix, 4-bit immediate, 4-bit register select
//
// executes the add group of a 4-bit core; holds acc, flags and the working registers
// assumes instr and instr_valid are presented on mclk; data memory reads combinationally
`timescale 1ns/1ps
`include "nibble_add_defines.vh"
module nibble_add_instruction_unit #(
	parameter WIDTH = 4,
	parameter AW    = 7
) (
	input  wire             mclk,
	input  wire             rst,
	input  wire             instr_valid,
	input  wire [15:0]      instr,
	output wire [AW-1:0]    mem_addr,
	input  wire [WIDTH-1:0] mem_rdata,
	output reg              mem_we,
	output reg  [AW-1:0]    mem_waddr,
	output reg  [WIDTH-1:0] mem_wdata,
	output reg  [WIDTH-1:0] acc,
	output reg              carry_flag,
	output reg              zero_flag,
	output wire             instr_hit
);
	localparam K_NONE   = 2'h0;
	localparam K_CARRY  = 2'h1;
	localparam K_PLAIN  = 2'h2;
	localparam K_KEEP   = 2'h3;
	localparam WREG_DEPTH = 16;
	localparam WREG_AW    = 4;

	wire [8:0]       mem_prefix;
	wire [7:0]       imm_prefix;
	wire [WIDTH-1:0] imm;
	wire [3:0]       wsel;
	wire [WIDTH-1:0] wreg_q;
	reg  [1:0]       kind;
	reg              is_imm;
	reg              writeback;
	reg  [WIDTH-1:0] opa;
	reg  [WIDTH-1:0] opb;
	reg              cin;
	wire [WIDTH-1:0] sum;
	wire             cout;
	wire             zero;
	wire             fire;
	wire             fwd_hit;
	wire [WIDTH-1:0] mem_operand;
	wire             wreg_we;
	wire             mem_wb;
	reg  [1:0]       mem_kind;
	reg              mem_wback;
	reg              mem_match;
	reg  [1:0]       imm_kind;
	reg              imm_wback;
	reg              imm_match;
	reg  [WIDTH-1:0] next_acc;
	reg              next_carry;
	reg              next_zero;
	reg              next_mem_we;
	reg  [AW-1:0]    next_mem_waddr;
	reg  [WIDTH-1:0] next_mem_wdata;

	assign mem_prefix = instr[`MEM_PREFIX_MSB:`MEM_PREFIX_LSB];
	assign imm_prefix = instr[`IMM_PREFIX_MSB:`IMM_PREFIX_LSB];
	assign imm        = instr[`IMM_MSB:`IMM_LSB];
	assign wsel       = instr[`WSEL_MSB:`WSEL_LSB];
	assign mem_addr   = instr[`ADDR_MSB:`ADDR_LSB];

	// memory-form decode; the 9-bit prefix leaves the low seven bits for the address
	always @* begin
		mem_kind  = K_NONE;
		mem_wback = 1'h0;
		mem_match = 1'h0;
		case (mem_prefix)
		`OP_CARRY_MEM: begin
			mem_kind  = K_CARRY;
			mem_wback = 1'h0;
			mem_match = 1'h1;
		end
		`OP_CARRY_WB_MEM: begin
			mem_kind  = K_CARRY;
			mem_wback = 1'h1;
			mem_match = 1'h1;
		end
		`OP_PLAIN_MEM: begin
			mem_kind  = K_PLAIN;
			mem_wback = 1'h0;
			mem_match = 1'h1;
		end
		`OP_PLAIN_WB_MEM: begin
			mem_kind  = K_PLAIN;
			mem_wback = 1'h1;
			mem_match = 1'h1;
		end
		`OP_KEEP_MEM: begin
			mem_kind  = K_KEEP;
			mem_wback = 1'h0;
			mem_match = 1'h1;
		end
		`OP_KEEP_WB_MEM: begin
			mem_kind  = K_KEEP;
			mem_wback = 1'h1;
			mem_match = 1'h1;
		end
		default: begin
			mem_kind  = K_NONE;
			mem_wback = 1'h0;
			mem_match = 1'h0;
		end
		endcase
	end

	// immediate-form decode; none of these prefixes can alias a memory prefix
	always @* begin
		imm_kind  = K_NONE;
		imm_wback = 1'h0;
		imm_match = 1'h0;
		case (imm_prefix)
		`OP_CARRY_IMM: begin
			imm_kind  = K_CARRY;
			imm_wback = 1'h0;
			imm_match = 1'h1;
		end
		`OP_CARRY_WB_IMM: begin
			imm_kind  = K_CARRY;
			imm_wback = 1'h1;
			imm_match = 1'h1;
		end
		`OP_PLAIN_IMM: begin
			imm_kind  = K_PLAIN;
			imm_wback = 1'h0;
			imm_match = 1'h1;
		end
		`OP_PLAIN_WB_IMM: begin
			imm_kind  = K_PLAIN;
			imm_wback = 1'h1;
			imm_match = 1'h1;
		end
		`OP_KEEP_IMM: begin
			imm_kind  = K_KEEP;
			imm_wback = 1'h0;
			imm_match = 1'h1;
		end
		`OP_KEEP_WB_IMM: begin
			imm_kind  = K_KEEP;
			imm_wback = 1'h1;
			imm_match = 1'h1;
		end
		default: begin
			imm_kind  = K_NONE;
			imm_wback = 1'h0;
			imm_match = 1'h0;
		end
		endcase
	end

	// memory prefixes win; an unmatched word falls to the immediate side as none
	always @* begin
		if (mem_match) begin
			kind      = mem_kind;
			is_imm    = 1'h0;
			writeback = mem_wback;
		end else begin
			kind      = imm_kind;
			is_imm    = 1'h1;
			writeback = imm_wback;
		end
	end

	assign fire      = instr_valid && (kind != K_NONE);
	assign instr_hit = fire;
	// the memory write lands one edge after the add that made it, so an add that
	// reads the same nibble right after it takes the pending value instead
	assign fwd_hit     = mem_we && (mem_waddr == mem_addr);
	assign mem_operand = fwd_hit ? mem_wdata : mem_rdata;
	assign wreg_we     = fire && is_imm && writeback;
	assign mem_wb      = fire && !is_imm && writeback;

	// operand select; only the carry kind feeds the old carry in
	always @* begin
		if (is_imm) begin
			opa = wreg_q;
			opb = imm;
		end else begin
			opa = mem_operand;
			opb = acc;
		end
		case (kind)
		K_CARRY: begin
			cin = carry_flag;
		end
		default: begin
			cin = 1'h0;
		end
		endcase
	end

	nibble_adder #(
		.WIDTH (WIDTH)
	) u_adder (
		.a    (opa),
		.b    (opb),
		.cin  (cin),
		.sum  (sum),
		.cout (cout),
		.zero (zero)
	);

	work_reg_file #(
		.WIDTH (WIDTH),
		.DEPTH (WREG_DEPTH),
		.AW    (WREG_AW)
	) u_wregs (
		.mclk    (mclk),
		.rst     (rst),
		.wr_en   (wreg_we),
		.wr_sel  (wsel),
		.wr_data (sum),
		.rd_sel  (wsel),
		.rd_data (wreg_q)
	);

	// accumulator and flags; refused words leave everything as it was
	always @* begin
		next_acc   = acc;
		next_carry = carry_flag;
		next_zero  = zero_flag;
		if (fire) begin
			next_acc  = sum;
			next_zero = zero;
			case (kind)
			K_CARRY: begin
				next_carry = cout;
			end
			K_PLAIN: begin
				next_carry = cout;
			end
			K_KEEP: begin
				next_carry = carry_flag;
			end
			K_NONE: begin
				next_carry = carry_flag;
			end
			default: begin
				next_carry = carry_flag;
			end
			endcase
		end
	end

	// memory write strobe stands one cycle; address and data hold until the next
	always @* begin
		next_mem_we    = 1'h0;
		next_mem_waddr = mem_waddr;
		next_mem_wdata = mem_wdata;
		if (mem_wb) begin
			next_mem_we    = 1'h1;
			next_mem_waddr = mem_addr;
			next_mem_wdata = sum;
		end
	end

	// acc, flags, working registers and the write request land on the same edge; the memory itself takes the write one edge later
	always @(posedge mclk) begin
		if (rst) begin
			acc        <= `ACC_RESET;
			carry_flag <= `FLAG_RESET;
			zero_flag  <= `FLAG_RESET;
			mem_we     <= 1'h0;
			mem_waddr  <= {AW{1'h0}};
			mem_wdata  <= {WIDTH{1'h0}};
		end else begin
			acc        <= next_acc;
			carry_flag <= next_carry;
			zero_flag  <= next_zero;
			mem_we     <= next_mem_we;
			mem_waddr  <= next_mem_waddr;
			mem_wdata  <= next_mem_wdata;
		end
	end
endmodule

// ### verif/data_mem_model.sv
// data memory partner: 128 nibbles, read without a clock
// assumes writes are strobed by mem_we on mclk
`timescale 1ns/1ps
module data_mem_model (
	input  wire       mclk,
	input  wire [6:0] mem_addr,
	output wire [3:0] mem_rdata,
	input  wire       mem_we,
	input  wire [6:0] mem_waddr,
	input  wire [3:0] mem_wdata
);
	logic [3:0] mem [0:127];
	// preset to the low address bits so the bench knows every nibble
	initial for (int i = 0; i < 128; i++) mem[i] = i[3:0];
	assign mem_rdata = mem[mem_addr];
	always @(posedge mclk) if (mem_we) mem[mem_waddr] <= mem_wdata;
endmodule

// ### verif/nibble_add_props.sv
// port assertions for the add unit
// assumes it is bound to nibble_add_instruction_unit
`timescale 1ns/1ps
module nibble_add_props (
	input wire        mclk,
	input wire        rst,
	input wire        instr_valid,
	input wire [15:0] instr,
	input wire [6:0]  mem_addr,
	input wire [3:0]  mem_rdata,
	input wire        mem_we,
	input wire [6:0]  mem_waddr,
	input wire [3:0]  mem_wdata,
	input wire [3:0]  acc,
	input wire        carry_flag,
	input wire        zero_flag,
	input wire        instr_hit
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire [8:0] mp = instr_valid ? instr[15:7] : 9'h1FF;
	// a write still pending in the memory is what the next add must see
	wire [3:0] mop = (mem_we && mem_waddr == mem_addr) ? mem_wdata : mem_rdata;
	wire [4:0] sn = mop + acc;
	wire [4:0] sc = mop + acc + carry_flag;
	property p_adc; mp == 9'h020 |=> {carry_flag, acc} == $past(sc); endproperty
	a_adc: assert property (p_adc) else $error("adc");
	property p_add; mp == 9'h030 |=> {carry_flag, acc} == $past(sn); endproperty
	a_add: assert property (p_add) else $error("add");
	property p_keep; mp == 9'h050 |=> acc == $past(sn[3:0]) && $stable(carry_flag); endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_cwb; mp == 9'h024 |=> mem_we && mem_waddr == $past(instr[6:0])
		&& {carry_flag, mem_wdata} == $past(sc); endproperty
	a_cwb: assert property (p_cwb) else $error("cwb");
	property p_pwb; mp == 9'h032 |=> mem_we && mem_wdata == acc && acc == $past(sn[3:0]); endproperty
	a_pwb: assert property (p_pwb) else $error("pwb");
	property p_adr; mem_addr == instr[6:0]; endproperty
	a_adr: assert property (p_adr) else $error("adr");
	property p_zf; instr_hit |=> zero_flag == (acc == 4'h0); endproperty
	a_zf: assert property (p_zf) else $error("zf");
	property p_ref; !instr_hit |=> !mem_we && $stable(acc) && $stable(carry_flag); endproperty
	a_ref: assert property (p_ref) else $error("ref");
endmodule

// ### verif/tb_top.sv
// bench for the add unit with a data memory partner
// assumes memory nibble n starts as the low bits of n
`timescale 1ns/1ps
module tb_top;
	logic        mclk = 0, rst = 1, instr_valid = 0, mem_we, carry_flag, zero_flag, instr_hit;
	logic [15:0] instr = 16'h0000;
	logic [6:0]  mem_addr, mem_waddr;
	logic [3:0]  mem_rdata, mem_wdata, acc;
	int          bad_count = 0, samples_checked = 0, cyc = 0;
	nibble_add_instruction_unit nibble_add_instruction_unit_i (.mclk, .rst, .instr_valid,
		.instr, .mem_addr, .mem_rdata, .mem_we, .mem_waddr, .mem_wdata, .acc, .carry_flag,
		.zero_flag, .instr_hit);
	data_mem_model data_mem_model_i (.mclk, .mem_addr, .mem_rdata, .mem_we, .mem_waddr,
		.mem_wdata);
	initial forever #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [6:0] got, input logic [6:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// e is {mem_we, carry, acc}; zero flag must follow acc
	task automatic step(input logic v, input logic [15:0] i, input logic [5:0] e);
		instr = i;
		instr_valid = v;
		@(posedge mclk);
		#1;
		cmp({zero_flag, mem_we, carry_flag, acc}, {e[3:0] == 4'h0, e});
	endtask
	task automatic test_mem();
		step(1, {9'h030, 7'h0F}, 6'h0F);
		step(1, {9'h020, 7'h01}, 6'h10);
		step(1, {9'h050, 7'h0E}, 6'h1E);
		step(1, {9'h030, 7'h03}, 6'h11);
		step(1, {9'h030, 7'h02}, 6'h03);
		step(1, {9'h024, 7'h05}, 6'h28);
		step(1, {9'h032, 7'h05}, 6'h30);
		step(1, {9'h024, 7'h16}, 6'h27);
		step(1, {9'h052, 7'h16}, 6'h2E);
		$display("mem done");
	endtask
	task automatic test_imm();
		step(1, 16'h1D93, 6'h09);
		step(1, 16'h0C73, 6'h10);
		step(1, 16'h0D53, 6'h0F);
		step(1, 16'h1C13, 6'h10);
		step(1, 16'h1C03, 6'h0F);
		step(1, 16'h1C04, 6'h00);
		step(1, 16'h0DF3, 6'h1E);
		step(1, 16'h2D23, 6'h10);
		step(1, 16'h2C53, 6'h15);
		$display("imm done");
	endtask
	// unknown codes and idle cycles must leave every result alone
	task automatic test_refuse();
		step(0, 16'h1C13, 6'h15);
		step(1, 16'hFFFF, 6'h15);
		instr_valid = 0;
		$display("refuse done");
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		#1 rst = 0;
		test_mem();
		test_imm();
		test_refuse();
		end_sim();
	end
endmodule
bind nibble_add_instruction_unit nibble_add_props props_i (.mclk, .rst, .instr_valid, .instr,
	.mem_addr, .mem_rdata, .mem_we, .mem_waddr, .mem_wdata, .acc, .carry_flag, .zero_flag,
	.instr_hit);
